// file: hw/mrrs_defs.vh
// Constants of the multiply, rotate, repeat and saturate datapath slice.
// Assumes it is included by the design and bench files of this slice only.
`ifndef MRRS_DEFS_VH
`define MRRS_DEFS_VH

// Instruction words (first word of each opcode; upper byte only for the repeats)
`define MRRS_OP_UMUL        16'h5647
`define MRRS_OP_XMUL        16'h5642
`define MRRS_OP_ROL         16'hff53
`define MRRS_OP_ROR         16'hff52
`define MRRS_OP_SAT         16'hff57
`define MRRS_OP_RPT_IMM     8'hf6
`define MRRS_OP_RPT_MEM     8'hf7

// Register map (byte addresses on the plain register port)
`define MRRS_AW             8
`define MRRS_REG_SUM        8'h00
`define MRRS_REG_PROD       8'h04
`define MRRS_REG_MCAND      8'h08
`define MRRS_REG_FLAGS      8'h0c
`define MRRS_REG_RTALLY     8'h10

// Flag register fields
`define MRRS_F_C            0
`define MRRS_F_N            1
`define MRRS_F_Z            2
`define MRRS_F_V            3
`define MRRS_F_OVC_LO       8
`define MRRS_F_OVC_HI       13

// Widths and values
`define MRRS_DW             32
`define MRRS_OVC_W          6
`define MRRS_RPT_W          16
`define MRRS_SAT_POS        32'h7fffffff
`define MRRS_SAT_NEG        32'h80000000
`define MRRS_ZERO32         32'h00000000
`define MRRS_ZERO_OVC       6'h00
`define MRRS_ZERO_RPT       16'h0000
`define MRRS_ONE_RPT        16'h0001

// Memory form of the repeat load: total cycles and wait-counter start
`define MRRS_RPT_MEM_CYC    4
`define MRRS_WAIT_START     2'h2
`define MRRS_WAIT_ZERO      2'h0
`define MRRS_WAIT_ONE       2'h1

`endif

// file: hw/mrrs_upper_mul.v
// Upper-half 32x32 multiplier, combinational.
// Assumes the caller registers the result; one core cycle of logic depth.
`timescale 1ns/10ps
`default_nettype none
`include "mrrs_defs.vh"

module mrrs_upper_mul (
    input  wire [`MRRS_DW-1:0] i_mcand,
    input  wire [`MRRS_DW-1:0] i_operand,
    input  wire                i_mixed,
    output wire [`MRRS_DW-1:0] o_upper
);

    wire signed [`MRRS_DW:0]     a_ext;
    wire signed [`MRRS_DW:0]     b_ext;
    wire signed [2*`MRRS_DW+1:0] prod;

    // One signed 33x33 product serves both forms: only the mixed form
    // sign-extends the multiplicand; the operand is always zero-extended
    assign a_ext   = {i_mixed & i_mcand[`MRRS_DW-1], i_mcand};
    assign b_ext   = {1'b0, i_operand};
    assign prod    = a_ext * b_ext;
    assign o_upper = prod[2*`MRRS_DW-1:`MRRS_DW];

endmodule // mrrs_upper_mul

`default_nettype wire

// file: hw/mrrs_core.v
// Datapath slice: upper-half multiplies, rotates through carry, repeat of the
// next instruction and accumulator saturation, with a plain register port.
// Assumes the decoder presents one instruction at a time with its operands
// and waits for o_ready; everything runs on one clock.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "mrrs_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - unsigned upper multiply writes product register
// - signed by unsigned upper multiply to product
// - multiplies need object mode, not repeatable
// - non-repeatable after repeat clears tally, once
// - rotate left through carry
// - rotate right through carry
// - rotate sets negative from bit 31
// - rotate sets zero when sum zero
// - rotates repeat N+1 times, final flags
// - immediate repeat loads 8-bit tally, one cycle
// - memory repeat loads 16-bit tally, four cycles
// - repeated instruction runs N+1 times total
// - repeat loop holds off interrupts throughout
// - saturate sum from signed overflow tally
// - saturate clears tally, carry; sets N,Z
module mrrs_core (
    input  wire                   i_clk,
    input  wire                   i_arst_n,
    // Instruction side
    input  wire                   i_instr_valid,
    input  wire [15:0]            i_opcode,
    input  wire [`MRRS_DW-1:0]    i_long_operand,
    input  wire [`MRRS_RPT_W-1:0] i_short_operand,
    input  wire                   i_object_mode,
    output reg                    o_ready,
    output reg                    o_int_hold,
    output reg                    o_illegal,
    // Register port
    input  wire [`MRRS_AW-1:0]    i_addr,
    input  wire [`MRRS_DW-1:0]    i_wdata,
    input  wire                   i_wr,
    input  wire                   i_rd,
    output reg  [`MRRS_DW-1:0]    o_rdata,
    // State views
    output reg  [`MRRS_DW-1:0]    o_sum,
    output reg  [`MRRS_DW-1:0]    o_product,
    output reg                    o_flag_c,
    output reg                    o_flag_n,
    output reg                    o_flag_z,
    output reg                    o_flag_v,
    output reg  [`MRRS_OVC_W-1:0] o_overflow_tally,
    output reg  [`MRRS_RPT_W-1:0] o_repeat_tally
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RPTW = 2'h1;
    localparam [1:0] ST_ROTR = 2'h2;

    reg  [1:0]             state_r;
    reg  [1:0]             state_nxt;
    reg  [1:0]             wait_r;
    reg  [1:0]             wait_nxt;
    reg                    dir_left_r;
    reg                    dir_left_nxt;
    reg                    pending_r;
    reg                    pending_nxt;
    reg  [`MRRS_RPT_W-1:0] rpt_hold_r;
    reg  [`MRRS_RPT_W-1:0] rpt_hold_nxt;
    reg  [`MRRS_DW-1:0]    mcand_r;
    reg  [`MRRS_DW-1:0]    mcand_nxt;
    reg  [`MRRS_DW-1:0]    sum_nxt;
    reg  [`MRRS_DW-1:0]    prod_nxt;
    reg                    c_nxt;
    reg                    n_nxt;
    reg                    z_nxt;
    reg                    v_nxt;
    reg  [`MRRS_OVC_W-1:0] ovc_nxt;
    reg  [`MRRS_RPT_W-1:0] tally_nxt;
    reg                    ready_nxt;
    reg                    hold_nxt;
    reg                    illegal_nxt;
    reg  [`MRRS_DW-1:0]    rdata_nxt;
    reg  [`MRRS_DW-1:0]    rot_sum;
    reg                    rot_c;
    reg                    rot_left;

    wire                   take;
    wire                   is_umul;
    wire                   is_xmul;
    wire                   is_rol;
    wire                   is_ror;
    wire                   is_sat;
    wire                   is_rpt_imm;
    wire                   is_rpt_mem;
    wire [`MRRS_DW-1:0]    mul_upper;
    wire [`MRRS_DW-1:0]    flags_word;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // An instruction is taken only while the slice is idle and says so
    assign take       = i_instr_valid & o_ready;
    assign is_umul    = (i_opcode == `MRRS_OP_UMUL);
    assign is_xmul    = (i_opcode == `MRRS_OP_XMUL);
    assign is_rol     = (i_opcode == `MRRS_OP_ROL);
    assign is_ror     = (i_opcode == `MRRS_OP_ROR);
    assign is_sat     = (i_opcode == `MRRS_OP_SAT);
    assign is_rpt_imm = (i_opcode[15:8] == `MRRS_OP_RPT_IMM);
    assign is_rpt_mem = (i_opcode[15:8] == `MRRS_OP_RPT_MEM);

    // Status word as software sees it
    assign flags_word = {{(`MRRS_DW-`MRRS_F_OVC_HI-1){1'b0}}, o_overflow_tally,
                         4'h0, o_flag_v, o_flag_z, o_flag_n, o_flag_c};

    ////////////////////////////////////////////////////////////////////////////
    // Multiplier

    mrrs_upper_mul u_mul (
        .i_mcand   (mcand_r),
        .i_operand (i_long_operand),
        .i_mixed   (is_xmul),
        .o_upper   (mul_upper)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Rotate through carry, direction from the opcode or the running loop

    always @* begin
        rot_left = (state_r == ST_ROTR) ? dir_left_r : is_rol;
        if (rot_left) begin
            {rot_c, rot_sum} = {o_sum, o_flag_c};
        end else begin
            {rot_sum, rot_c} = {o_flag_c, o_sum};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the datapath and the sequencer

    always @* begin
        state_nxt    = state_r;
        wait_nxt     = wait_r;
        dir_left_nxt = dir_left_r;
        pending_nxt  = pending_r;
        rpt_hold_nxt = rpt_hold_r;
        mcand_nxt    = mcand_r;
        sum_nxt      = o_sum;
        prod_nxt     = o_product;
        c_nxt        = o_flag_c;
        n_nxt        = o_flag_n;
        z_nxt        = o_flag_z;
        v_nxt        = o_flag_v;
        ovc_nxt      = o_overflow_tally;
        tally_nxt    = o_repeat_tally;
        ready_nxt    = o_ready;
        hold_nxt     = o_int_hold;
        illegal_nxt  = 1'b0;

        // Software writes first; an instruction in the same cycle overrides
        if (i_wr) begin
            case (i_addr)
                `MRRS_REG_SUM: begin
                    sum_nxt = i_wdata;
                end
                `MRRS_REG_PROD: begin
                    prod_nxt = i_wdata;
                end
                `MRRS_REG_MCAND: begin
                    mcand_nxt = i_wdata;
                end
                `MRRS_REG_FLAGS: begin
                    c_nxt   = i_wdata[`MRRS_F_C];
                    n_nxt   = i_wdata[`MRRS_F_N];
                    z_nxt   = i_wdata[`MRRS_F_Z];
                    v_nxt   = i_wdata[`MRRS_F_V];
                    ovc_nxt = i_wdata[`MRRS_F_OVC_HI:`MRRS_F_OVC_LO];
                end
                default: begin
                end
            endcase
        end

        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    // Any instruction other than a repeat closes a pending repeat
                    pending_nxt = 1'b0;
                    if (is_rpt_imm) begin
                        // Eight-bit constant, done in this cycle
                        tally_nxt   = {8'h00, i_opcode[7:0]};
                        pending_nxt = 1'b1;
                        hold_nxt    = 1'b1;
                    end else if (is_rpt_mem) begin
                        // Operand captured now; the tally loads after the memory access latency
                        rpt_hold_nxt = i_short_operand;
                        tally_nxt    = `MRRS_ZERO_RPT;
                        wait_nxt     = `MRRS_WAIT_START;
                        state_nxt    = ST_RPTW;
                        ready_nxt    = 1'b0;
                        hold_nxt     = 1'b1;
                    end else if (is_rol | is_ror) begin
                        sum_nxt = rot_sum;
                        c_nxt   = rot_c;
                        n_nxt   = rot_sum[`MRRS_DW-1];
                        z_nxt   = (rot_sum == `MRRS_ZERO32);
                        if (pending_r && (o_repeat_tally != `MRRS_ZERO_RPT)) begin
                            // First of N+1 executions; N more follow back to back
                            dir_left_nxt = is_rol;
                            state_nxt    = ST_ROTR;
                            ready_nxt    = 1'b0;
                        end else begin
                            hold_nxt = 1'b0;
                        end
                    end else begin
                        // Not repeatable: runs once and drops the tally
                        tally_nxt = `MRRS_ZERO_RPT;
                        hold_nxt  = 1'b0;
                        if (is_umul | is_xmul) begin
                            if (i_object_mode) begin
                                prod_nxt = mul_upper;
                            end else begin
                                illegal_nxt = 1'b1;
                            end
                        end else if (is_sat) begin
                            // Single cycle, tally sign picks the limit
                            if (o_overflow_tally != `MRRS_ZERO_OVC) begin
                                if (o_overflow_tally[`MRRS_OVC_W-1]) begin
                                    sum_nxt = `MRRS_SAT_NEG;
                                end else begin
                                    sum_nxt = `MRRS_SAT_POS;
                                end
                                v_nxt = 1'b1;
                            end else begin
                                v_nxt = 1'b0;
                            end
                            ovc_nxt = `MRRS_ZERO_OVC;
                            c_nxt   = 1'b0;
                            n_nxt   = sum_nxt[`MRRS_DW-1];
                            z_nxt   = (sum_nxt == `MRRS_ZERO32);
                        end
                    end
                end
            end
            ST_RPTW: begin
                if (wait_r == `MRRS_WAIT_ZERO) begin
                    tally_nxt   = rpt_hold_r;
                    pending_nxt = 1'b1;
                    state_nxt   = ST_IDLE;
                    ready_nxt   = 1'b1;
                end else begin
                    wait_nxt = wait_r - `MRRS_WAIT_ONE;
                end
            end
            ST_ROTR: begin
                // One more execution per cycle; flags follow each, so the last wins
                sum_nxt   = rot_sum;
                c_nxt     = rot_c;
                n_nxt     = rot_sum[`MRRS_DW-1];
                z_nxt     = (rot_sum == `MRRS_ZERO32);
                tally_nxt = o_repeat_tally - `MRRS_ONE_RPT;
                if (o_repeat_tally == `MRRS_ONE_RPT) begin
                    state_nxt = ST_IDLE;
                    ready_nxt = 1'b1;
                    hold_nxt  = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
                hold_nxt  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux, data valid in the cycle after the strobe

    always @* begin
        rdata_nxt = `MRRS_ZERO32;
        if (i_rd) begin
            case (i_addr)
                `MRRS_REG_SUM:    rdata_nxt = o_sum;
                `MRRS_REG_PROD:   rdata_nxt = o_product;
                `MRRS_REG_MCAND:  rdata_nxt = mcand_r;
                `MRRS_REG_FLAGS:  rdata_nxt = flags_word;
                `MRRS_REG_RTALLY: rdata_nxt = {16'h0000, o_repeat_tally};
                default:          rdata_nxt = `MRRS_ZERO32;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State flops

    // Every output is a flop so the decoder sees no combinational paths
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r          <= ST_IDLE;
            wait_r           <= `MRRS_WAIT_ZERO;
            dir_left_r       <= 1'b0;
            pending_r        <= 1'b0;
            rpt_hold_r       <= `MRRS_ZERO_RPT;
            mcand_r          <= `MRRS_ZERO32;
            o_sum            <= `MRRS_ZERO32;
            o_product        <= `MRRS_ZERO32;
            o_flag_c         <= 1'b0;
            o_flag_n         <= 1'b0;
            o_flag_z         <= 1'b0;
            o_flag_v         <= 1'b0;
            o_overflow_tally <= `MRRS_ZERO_OVC;
            o_repeat_tally   <= `MRRS_ZERO_RPT;
            o_ready          <= 1'b1;
            o_int_hold       <= 1'b0;
            o_illegal        <= 1'b0;
            o_rdata          <= `MRRS_ZERO32;
        end else begin
            state_r          <= state_nxt;
            wait_r           <= wait_nxt;
            dir_left_r       <= dir_left_nxt;
            pending_r        <= pending_nxt;
            rpt_hold_r       <= rpt_hold_nxt;
            mcand_r          <= mcand_nxt;
            o_sum            <= sum_nxt;
            o_product        <= prod_nxt;
            o_flag_c         <= c_nxt;
            o_flag_n         <= n_nxt;
            o_flag_z         <= z_nxt;
            o_flag_v         <= v_nxt;
            o_overflow_tally <= ovc_nxt;
            o_repeat_tally   <= tally_nxt;
            o_ready          <= ready_nxt;
            o_int_hold       <= hold_nxt;
            o_illegal        <= illegal_nxt;
            o_rdata          <= rdata_nxt;
        end
    end

endmodule // mrrs_core

`default_nettype wire

// file: bench/mrrs_dec_model.sv
// Behavioural decoder: presents one instruction with its operands.
// Assumes the core takes it on a rising edge where o_ready is high.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////
module mrrs_dec_model (
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    output var  logic        o_instr_valid,
    output var  logic [15:0] o_opcode,
    output var  logic [31:0] o_long_operand,
    output var  logic [15:0] o_short_operand,
    output var  logic        o_object_mode
);
    // Idle outputs at time zero
    initial begin
        o_instr_valid = 1'b0;
        o_opcode = 16'h0000;
        o_long_operand = 32'h00000000;
        o_short_operand = 16'h0000;
        o_object_mode = 1'b0;
    end

    // Hold until taken or 64 cycles pass; inverted operands on release expose stale use
    task issue(input logic [15:0] op, input logic [31:0] lop, input logic [15:0] sop,
               input logic om, output logic ok);
        integer i;
        begin
            ok = 1'b0;
            @(posedge i_clk);
            o_instr_valid <= 1'b1;
            o_opcode <= op;
            o_long_operand <= lop;
            o_short_operand <= sop;
            o_object_mode <= om;
            for (i = 0; i < 64 && !ok; i = i + 1) begin
                @(negedge i_clk);
                ok = i_ready;
            end
            @(posedge i_clk);
            o_instr_valid <= 1'b0;
            o_opcode <= ~op;
            o_long_operand <= ~lop;
            o_short_operand <= ~sop;
            o_object_mode <= ~om;
        end
    endtask
endmodule // mrrs_dec_model
`default_nettype wire

// file: bench/mrrs_core_chk.sv
// Port-level checker for the datapath slice.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "mrrs_defs.vh"
////////////////////////////////////////////////////////////
module mrrs_core_chk (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        i_instr_valid,
    input wire logic [15:0] i_opcode,
    input wire logic [15:0] i_short_operand,
    input wire logic        i_object_mode,
    input wire logic        o_ready,
    input wire logic        o_int_hold,
    input wire logic        o_illegal,
    input wire logic [31:0] o_sum,
    input wire logic [31:0] o_product,
    input wire logic        o_flag_c,
    input wire logic        o_flag_n,
    input wire logic        o_flag_z,
    input wire logic        o_flag_v,
    input wire logic [5:0]  o_overflow_tally,
    input wire logic [15:0] o_repeat_tally
);
    // Decoded takes of each instruction kind, then the overflow and repeat tally tests
    wire logic take    = i_instr_valid && o_ready;
    wire logic rot_l   = take && i_opcode == `MRRS_OP_ROL;
    wire logic rot_r   = take && i_opcode == `MRRS_OP_ROR;
    wire logic satur   = take && i_opcode == `MRRS_OP_SAT;
    wire logic mul     = take && (i_opcode == `MRRS_OP_UMUL || i_opcode == `MRRS_OP_XMUL);
    wire logic rep_imm = take && i_opcode[15:8] == `MRRS_OP_RPT_IMM;
    wire logic rep_mem = take && i_opcode[15:8] == `MRRS_OP_RPT_MEM;
    wire logic ov_pos  = !o_overflow_tally[5] && o_overflow_tally != `MRRS_ZERO_OVC;
    wire logic once    = o_repeat_tally == `MRRS_ZERO_RPT;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_rotl_carry: assert property (rot_l && once |=>
        o_sum == {$past(o_sum[30:0]), $past(o_flag_c)} && o_flag_c == $past(o_sum[31]))
        else $error("rotate left result wrong");
    a_rotr_carry: assert property (rot_r && once |=>
        o_sum == {$past(o_flag_c), $past(o_sum[31:1])} && o_flag_c == $past(o_sum[0]))
        else $error("rotate right result wrong");
    a_rot_flags: assert property ((rot_l || rot_r) && once |=>
        o_flag_n == o_sum[31] && o_flag_z == (o_sum == `MRRS_ZERO32)) else $error("rotate flags wrong");
    a_rot_repeat_hold: assert property ((rot_l || rot_r) && !once |=> !o_ready && o_int_hold)
        else $error("repeated rotate not held");
    a_tally_step: assert property (o_int_hold && !o_ready && !once |=>
        o_repeat_tally == $past(o_repeat_tally) - `MRRS_ONE_RPT) else $error("tally step wrong");
    a_mul_keeps_flags: assert property (mul |=>
        $stable({o_flag_c, o_flag_n, o_flag_z, o_flag_v})) else $error("multiply touched flags");
    a_mul_needs_mode: assert property (mul && !i_object_mode |=>
        o_illegal && $stable(o_product) ##1 !o_illegal) else $error("multiply without mode wrong");
    a_sat_positive: assert property (satur && ov_pos |=> o_sum == `MRRS_SAT_POS && o_flag_v
        && !o_flag_c && !o_flag_n && !o_flag_z && o_overflow_tally == `MRRS_ZERO_OVC) else $error("positive sat wrong");
    a_sat_negative: assert property (satur && o_overflow_tally[5] |=> o_sum == `MRRS_SAT_NEG
        && o_flag_v && !o_flag_c && o_flag_n && o_overflow_tally == `MRRS_ZERO_OVC) else $error("negative sat wrong");
    a_sat_idle: assert property (satur && o_overflow_tally == `MRRS_ZERO_OVC |=>
        $stable(o_sum) && !o_flag_v && !o_flag_c) else $error("zero-tally sat wrong");
    a_rep_imm_load: assert property (rep_imm |=> o_ready && o_int_hold
        && o_repeat_tally == ($past(i_opcode) & 16'h00ff)) else $error("immediate repeat load wrong");
    a_rep_mem_load: assert property (rep_mem |=> !o_ready [*3] ##1
        (o_ready && o_repeat_tally == $past(i_short_operand, 4))) else $error("memory repeat load wrong");
    a_nonrep_once: assert property ((satur || mul) && o_int_hold |=> once && o_ready)
        else $error("non-repeatable instruction repeated");
endmodule // mrrs_core_chk

bind mrrs_core mrrs_core_chk u_chk (.*);
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the datapath slice.
// Assumes the decoder model drives the instruction side; bench drives registers.
`timescale 1ns/10ps
`default_nettype none
`include "mrrs_defs.vh"
////////////////////////////////////////////////////////////
module testbench;
    logic             i_clk, i_arst_n, i_wr, i_rd;
    logic [7:0]       i_addr;
    logic [31:0]      i_wdata;
    wire logic        i_instr_valid, i_object_mode, o_ready, o_int_hold, o_illegal;
    wire logic        o_flag_c, o_flag_n, o_flag_z, o_flag_v;
    wire logic [15:0] i_opcode, i_short_operand, o_repeat_tally;
    wire logic [31:0] i_long_operand, o_rdata, o_sum, o_product;
    wire logic [5:0]  o_overflow_tally;
    integer           n_errors, comparisons;

    // Free-running core clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    mrrs_dec_model dec (.i_clk(i_clk), .i_ready(o_ready), .o_instr_valid(i_instr_valid), .o_opcode(i_opcode),
        .o_long_operand(i_long_operand), .o_short_operand(i_short_operand), .o_object_mode(i_object_mode));
    mrrs_core DUT (.*);

    ////////////////////////////////////////////////////////////
    // Shared checks, bus cycles and reference model
    task results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_errors = n_errors + 1;
        end
    endtask
    task chk_state(input logic [32:0] e);
        chk("sum", e[31:0], o_sum);
        chk("carry", {31'h0, e[32]}, {31'h0, o_flag_c});
        chk("negative", {31'h0, e[31]}, {31'h0, o_flag_n});
        chk("zero", {31'h0, e[31:0] == 32'h0}, {31'h0, o_flag_z});
    endtask
    function logic [32:0] rot(input logic [32:0] e, input logic left);
        rot = left ? {e[31:0], e[32]} : {e[0], e[32], e[31:1]};
    endfunction
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(nm, e, o_rdata);
    endtask
    // Issue one instruction; a refused hand-off ends the run
    task run(input logic [15:0] op, input logic [31:0] lop, input logic [15:0] sop, input logic om);
        logic ok;
        dec.issue(op, lop, sop, om, ok);
        if (!ok) begin
            n_errors = n_errors + 1;
            results;
        end
        @(negedge i_clk);
    endtask
    // Count busy cycles, bounded so a stuck core cannot hang the run
    task busy(output integer n);
        n = 0;
        while (!o_ready && n < 300) begin
            n = n + 1;
            @(negedge i_clk);
        end
        if (n == 300) begin
            n_errors = n_errors + 1;
            results;
        end
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios
    task t_mul;
        logic [63:0] p;
        wr(`MRRS_REG_MCAND, 32'hfffffffe);
        wr(`MRRS_REG_FLAGS, 32'h00000005);
        run(`MRRS_OP_UMUL, 32'h80000001, 16'h0000, 1'b1);
        p = 64'h00000000fffffffe * 64'h0000000080000001;
        chk("product", p[63:32], o_product);
        run(`MRRS_OP_XMUL, 32'h80000001, 16'h0000, 1'b1);
        p = 64'hfffffffffffffffe * 64'h0000000080000001;
        chk("product", p[63:32], o_product);
        run(`MRRS_OP_UMUL, 32'hffffffff, 16'h0000, 1'b0);
        chk("illegal", 32'h1, {31'h0, o_illegal});
        chk("product", p[63:32], o_product);
        rd(`MRRS_REG_FLAGS, 32'h00000005, "flags");
    endtask
    task rot1(input logic [31:0] s, input logic c, input logic left);
        wr(`MRRS_REG_SUM, s);
        wr(`MRRS_REG_FLAGS, {31'h0, c});
        run(left ? `MRRS_OP_ROL : `MRRS_OP_ROR, 32'h0, 16'h0, 1'b1);
        chk_state(rot({c, s}, left));
    endtask
    task t_rpt(input logic mem);
        integer n, i;
        logic [32:0] e;
        wr(`MRRS_REG_SUM, 32'h1234567f);
        wr(`MRRS_REG_FLAGS, 32'h00000001);
        run(mem ? {`MRRS_OP_RPT_MEM, 8'h00} : {`MRRS_OP_RPT_IMM, 8'hff}, 32'h0, 16'h0003, 1'b1);
        busy(n);
        chk("load cycles", mem ? 32'h3 : 32'h0, n);
        chk("tally", mem ? 32'h3 : 32'hff, {16'h0, o_repeat_tally});
        run(mem ? `MRRS_OP_ROR : `MRRS_OP_ROL, 32'h0, 16'h0, 1'b1);
        chk("hold", 32'h1, {31'h0, o_int_hold});
        busy(n);
        chk("repeat cycles", mem ? 32'h3 : 32'hff, n);
        e = {1'b1, 32'h1234567f};
        for (i = 0; i <= (mem ? 3 : 255); i = i + 1) e = rot(e, !mem);
        chk_state(e);
        chk("tally end", 32'h0, {16'h0, o_repeat_tally});
        chk("hold end", 32'h0, {31'h0, o_int_hold});
    endtask
    task sat1(input logic [5:0] ov, input logic [31:0] s, input logic [31:0] es, input logic v);
        wr(`MRRS_REG_SUM, s);
        wr(`MRRS_REG_FLAGS, {18'h0, ov, 8'h01});
        run(`MRRS_OP_SAT, 32'h0, 16'h0, 1'b1);
        chk_state({1'b0, es});
        chk("overflow", {31'h0, v}, {31'h0, o_flag_v});
        chk("ov tally", 32'h0, {26'h0, o_overflow_tally});
    endtask
    task t_nonrep;
        wr(`MRRS_REG_FLAGS, 32'h00000001);
        run({`MRRS_OP_RPT_IMM, 8'h05}, 32'h0, 16'h0, 1'b1);
        run(`MRRS_OP_SAT, 32'h0, 16'h0, 1'b1);
        chk("tally", 32'h0, {16'h0, o_repeat_tally});
        chk("ready", 32'h1, {31'h0, o_ready});
        chk("carry", 32'h0, {31'h0, o_flag_c});
    endtask
    task t_regs;
        rd(8'h14, 32'h0, "unmapped");
        wr(`MRRS_REG_RTALLY, 32'h000000ff);
        rd(`MRRS_REG_RTALLY, 32'h0, "tally ro");
        rd(`MRRS_REG_MCAND, 32'hfffffffe, "mcand");
    endtask

    ////////////////////////////////////////////////////////////
    // Reset, then the scenarios in turn
    initial begin
        i_arst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        n_errors = 0;
        comparisons = 0;
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_mul;
        t_regs;
        rot1(32'h80000000, 1'b0, 1'b1);
        rot1(32'h40000001, 1'b1, 1'b1);
        rot1(32'h00000001, 1'b1, 1'b0);
        rot1(32'h00000001, 1'b0, 1'b0);
        t_rpt(1'b0);
        t_rpt(1'b1);
        t_nonrep;
        sat1(6'h1f, 32'h00000001, 32'h7fffffff, 1'b1);
        sat1(6'h20, 32'h00000001, 32'h80000000, 1'b1);
        sat1(6'h00, 32'h00000000, 32'h00000000, 1'b0);
        results;
    end
endmodule // testbench
`default_nettype wire
